// ==== adc_conv_defs.svh ====
// Constants for the conversion control block
//
// Contract
// - Eight-, ten- or twelve-bit results, twenty-four external input channels
// - Channel select also reaches ground, supply, temperature, bandgap
// - Clock from bus, external or internal, then divider
// - Short or long sampling; low-power slower setting
// - Counter trigger pulse starts conversion, even in stop
// - Software trigger: control write starts the chosen channel
// - Compare mode flags only when relation holds
// - Completion sets done flag and loads result
// - Configuration 0x44: bus clock, 12-bit, short, div4
// - Pin control bit disables digital pin function
`ifndef ADC_CONV_DEFS_SVH
`define ADC_CONV_DEFS_SVH

`define ADC_CFG_LP        7
`define ADC_CFG_DIV_HI    6
`define ADC_CFG_DIV_LO    5
`define ADC_CFG_LONG      4
`define ADC_CFG_MODE_HI   3
`define ADC_CFG_MODE_LO   2
`define ADC_CFG_CLK_HI    1
`define ADC_CFG_CLK_LO    0

`define ADC_SC1_AIEN      6
`define ADC_SC1_CONT      5
`define ADC_SC1_CH_HI     4
`define ADC_SC1_CH_LO     0

`define ADC_SC2_HWTRG     6
`define ADC_SC2_CMPEN     5
`define ADC_SC2_CMPGE     4

`define ADC_CLK_BUS       2'h0
`define ADC_CLK_BUS_HALF  2'h1
`define ADC_CLK_EXT       2'h2
`define ADC_CLK_INT       2'h3

`define ADC_MODE_8        2'h0
`define ADC_MODE_12       2'h1
`define ADC_MODE_10       2'h2
`define ADC_BITS_8        4'h8
`define ADC_BITS_10       4'ha
`define ADC_BITS_12       4'hc

`define ADC_CH_LAST_EXT   5'h17
`define ADC_CH_TEMP       5'h1a
`define ADC_CH_BANDGAP    5'h1b
`define ADC_CH_SUPPLY     5'h1d
`define ADC_CH_GROUND     5'h1e
`define ADC_CH_OFF        5'h1f

`define ADC_SHORT_SAMPLE  5'h04
`define ADC_LONG_SAMPLE   5'h18

`define ADC_CFG_EXAMPLE   8'h44
`define ADC_SC2_CMP_GE_SW 8'h30
`define ADC_SC2_PLAIN_SW  8'h00

`endif

// ==== adc_conv_pkg.sv ====
// Types for the conversion control block
package adc_conv_pkg;

    typedef enum logic [0:0] {CTL_IDLE, CTL_CONVERT} ctl_phase_t;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_TRIAL} seq_phase_t;

    typedef struct packed {
        ctl_phase_t  phase;
        logic [4:0]  chan;
        logic        aien;
        logic        cont;
        logic        done;
        logic [11:0] result;
        logic        irq;
        logic [23:0] ddis;
        logic [3:0]  div_cnt;
        logic        half;
        logic        ext_prev;
        logic        int_prev;
        logic        tick;
        logic        start;
    } ctl_state_t;

    typedef struct packed {
        seq_phase_t  phase;
        logic [4:0]  cnt;
        logic [3:0]  bitp;
        logic [11:0] code;
        logic        done;
        logic [11:0] result;
        logic        sampling;
    } seq_state_t;

endpackage

// ==== adc_sar_sequencer.sv ====
// Sample and successive approximation sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adc_conv_defs.svh"
module adc_sar_sequencer
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        tick_i,
    input  wire logic        start_i,
    input  wire logic        long_i,
    input  wire logic [3:0]  nbits_i,
    input  wire logic        cmp_hi_i,
    output logic             sampling_o,
    output logic [11:0]      trial_code_o,
    output logic             done_o,
    output logic [11:0]      result_o
);
    adc_conv_pkg::seq_state_t s_reg;
    adc_conv_pkg::seq_state_t s_next;
    logic [4:0]               samp_last;

    always_comb
    begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        samp_last   = long_i ? `ADC_LONG_SAMPLE - 5'h01 : `ADC_SHORT_SAMPLE - 5'h01;
        if (start_i)
        begin
            s_next.phase = adc_conv_pkg::SEQ_SAMPLE;
            s_next.cnt   = 5'h00;
        end
        else if (tick_i)
        begin
            case (s_reg.phase)
                adc_conv_pkg::SEQ_SAMPLE:
                begin
                    if (s_reg.cnt == samp_last)
                    begin
                        s_next.phase = adc_conv_pkg::SEQ_TRIAL;
                        s_next.bitp  = nbits_i - 4'h1;
                        s_next.code  = 12'h001 << (nbits_i - 4'h1);
                    end
                    else
                    begin
                        s_next.cnt = s_reg.cnt + 5'h01;
                    end
                end
                adc_conv_pkg::SEQ_TRIAL:
                begin
                    if (!cmp_hi_i)
                    begin
                        s_next.code[s_reg.bitp] = 1'b0;
                    end
                    if (s_reg.bitp == 4'h0)
                    begin
                        s_next.phase  = adc_conv_pkg::SEQ_IDLE;
                        s_next.done   = 1'b1;
                        s_next.result = s_next.code;
                    end
                    else
                    begin
                        s_next.bitp                   = s_reg.bitp - 4'h1;
                        s_next.code[s_reg.bitp - 4'h1] = 1'b1;
                    end
                end
                default:
                begin
                    s_next.phase = adc_conv_pkg::SEQ_IDLE;
                end
            endcase
        end
        s_next.sampling = s_next.phase == adc_conv_pkg::SEQ_SAMPLE;
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign sampling_o   = s_reg.sampling;
    assign trial_code_o = s_reg.code;
    assign done_o       = s_reg.done;
    assign result_o     = s_reg.result;

    long_sample_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(sampling_o) && long_i |-> sampling_o [*8])
        else $error("Long sampling ended too early");
endmodule
`default_nettype wire

// ==== adc_conversion_control.sv ====
// Conversion control: triggers, clocking, compare, result and flag
`timescale 1ns/100ps
`default_nettype none
`include "adc_conv_defs.svh"
module adc_conversion_control
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  converter_config_reg_i,
    input  wire logic        conv_control_one_wr_i,
    input  wire logic [7:0]  conv_control_one_i,
    input  wire logic [7:0]  conv_control_two_i,
    input  wire logic [11:0] compare_value_reg_i,
    input  wire logic [23:0] pin_analog_control_i,
    input  wire logic        result_read_i,
    input  wire logic        rtc_trigger_i,
    input  wire logic        ext_ref_clk_i,
    input  wire logic        int_async_clk_i,
    input  wire logic        analog_cmp_hi_i,
    output logic             conversion_done_flag_o,
    output logic [11:0]      conversion_result_reg_o,
    output logic             conv_irq_o,
    output logic [4:0]       channel_route_o,
    output logic [23:0]      pin0_analog_select_o,
    output logic             sampling_o,
    output logic [11:0]      trial_code_o
);
    adc_conv_pkg::ctl_state_t s_reg;
    adc_conv_pkg::ctl_state_t s_next;
    logic                     seq_done;
    logic [11:0]              seq_result;
    logic [3:0]               nbits;
    logic [4:0]               div_last;
    logic [2:0]               div_shift;
    logic                     src_edge;
    logic                     hw_trig;
    logic                     cmp_met;
    logic                     wr_go;

    function automatic logic chan_valid(input logic [4:0] ch);
        chan_valid = ch != `ADC_CH_OFF;
    endfunction

    assign hw_trig = conv_control_two_i[`ADC_SC2_HWTRG];
    assign wr_go   = conv_control_one_wr_i && chan_valid(conv_control_one_i[`ADC_SC1_CH_HI:`ADC_SC1_CH_LO]);

    always_comb
    begin
        case (converter_config_reg_i[`ADC_CFG_MODE_HI:`ADC_CFG_MODE_LO])
            `ADC_MODE_8:  nbits = `ADC_BITS_8;
            `ADC_MODE_10: nbits = `ADC_BITS_10;
            default:      nbits = `ADC_BITS_12;
        endcase
    end

    always_comb
    begin
        s_next          = s_reg;
        s_next.tick     = 1'b0;
        s_next.start    = 1'b0;
        s_next.half     = ~s_reg.half;
        s_next.ext_prev = ext_ref_clk_i;
        s_next.int_prev = int_async_clk_i;
        case (converter_config_reg_i[`ADC_CFG_CLK_HI:`ADC_CFG_CLK_LO])
            `ADC_CLK_BUS:      src_edge = 1'b1;
            `ADC_CLK_BUS_HALF: src_edge = s_reg.half;
            `ADC_CLK_EXT:      src_edge = ext_ref_clk_i && !s_reg.ext_prev;
            default:           src_edge = int_async_clk_i && !s_reg.int_prev;
        endcase
        // Low power doubles the divide for a slower conversion rate
        div_shift = {1'b0, converter_config_reg_i[`ADC_CFG_DIV_HI:`ADC_CFG_DIV_LO]}
                    + {2'h0, converter_config_reg_i[`ADC_CFG_LP]};
        div_last  = (5'h01 << div_shift) - 5'h01;
        if (src_edge)
        begin
            if ({1'b0, s_reg.div_cnt} >= div_last[4:0] || div_last[4])
            begin
                s_next.div_cnt = 4'h0;
                s_next.tick    = ({1'b0, s_reg.div_cnt} == div_last) || !div_last[4];
                if (div_last[4] && s_reg.div_cnt != 4'hf)
                begin
                    s_next.div_cnt = s_reg.div_cnt + 4'h1;
                    s_next.tick    = 1'b0;
                end
            end
            else
            begin
                s_next.div_cnt = s_reg.div_cnt + 4'h1;
            end
        end
        if (conv_control_two_i[`ADC_SC2_CMPGE])
        begin
            cmp_met = seq_result >= compare_value_reg_i;
        end
        else
        begin
            cmp_met = seq_result < compare_value_reg_i;
        end
        if (result_read_i)
        begin
            s_next.done = 1'b0;
        end
        if (conv_control_one_wr_i)
        begin
            s_next.chan  = conv_control_one_i[`ADC_SC1_CH_HI:`ADC_SC1_CH_LO];
            s_next.aien  = conv_control_one_i[`ADC_SC1_AIEN];
            s_next.cont  = conv_control_one_i[`ADC_SC1_CONT];
            s_next.done  = 1'b0;
            s_next.phase = adc_conv_pkg::CTL_IDLE;
            if (wr_go && !hw_trig)
            begin
                s_next.phase = adc_conv_pkg::CTL_CONVERT;
                s_next.start = 1'b1;
            end
        end
        else
        begin
            if (hw_trig && rtc_trigger_i && chan_valid(s_reg.chan)
                && s_reg.phase == adc_conv_pkg::CTL_IDLE)
            begin
                s_next.phase = adc_conv_pkg::CTL_CONVERT;
                s_next.start = 1'b1;
            end
            if (seq_done && s_reg.phase == adc_conv_pkg::CTL_CONVERT)
            begin
                if (!conv_control_two_i[`ADC_SC2_CMPEN] || cmp_met)
                begin
                    s_next.done   = 1'b1;
                    s_next.result = seq_result;
                end
                if (s_reg.cont && !hw_trig)
                begin
                    s_next.start = 1'b1;
                end
                else
                begin
                    s_next.phase = adc_conv_pkg::CTL_IDLE;
                end
            end
        end
        s_next.irq  = s_next.done && s_next.aien;
        s_next.ddis = pin_analog_control_i;
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_reg      <= '0;
            s_reg.chan <= `ADC_CH_OFF;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    adc_sar_sequencer u_seq
    (
        .mclk_i       (mclk_i),
        .rst_i        (rst_i),
        .tick_i       (s_reg.tick),
        .start_i      (s_reg.start),
        .long_i       (converter_config_reg_i[`ADC_CFG_LONG]),
        .nbits_i      (nbits),
        .cmp_hi_i     (analog_cmp_hi_i),
        .sampling_o   (sampling_o),
        .trial_code_o (trial_code_o),
        .done_o       (seq_done),
        .result_o     (seq_result)
    );

    assign conversion_done_flag_o  = s_reg.done;
    assign conversion_result_reg_o = s_reg.result;
    assign conv_irq_o              = s_reg.irq;
    assign channel_route_o         = s_reg.chan;
    assign pin0_analog_select_o    = s_reg.ddis;

    write_clears_done_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        conv_control_one_wr_i |=> !conversion_done_flag_o)
        else $error("Control write did not clear done flag");

    write_starts_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_go && !hw_trig |=> s_reg.start ##1 sampling_o)
        else $error("Software write did not start a conversion");

    rtc_trigger_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !conv_control_one_wr_i && hw_trig && rtc_trigger_i && chan_valid(s_reg.chan)
        && s_reg.phase == adc_conv_pkg::CTL_IDLE |=> s_reg.start)
        else $error("Counter trigger did not start a conversion");

    compare_miss_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_done && !conv_control_one_wr_i && !result_read_i && conv_control_two_i == `ADC_SC2_CMP_GE_SW
        && seq_result < compare_value_reg_i |=> $stable(conversion_result_reg_o)
        && conversion_done_flag_o == $past(conversion_done_flag_o))
        else $error("Compare miss changed the result");

    done_result_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_done && s_reg.phase == adc_conv_pkg::CTL_CONVERT && !conv_control_one_wr_i
        && conv_control_two_i == `ADC_SC2_PLAIN_SW |=> conversion_done_flag_o
        && conversion_result_reg_o == $past(seq_result))
        else $error("Completion did not load result and flag");

    pin_control_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        ##1 pin0_analog_select_o == $past(pin_analog_control_i))
        else $error("Pin analog select does not follow control");

    route_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        conv_control_one_wr_i |=> channel_route_o == $past(conv_control_one_i[`ADC_SC1_CH_HI:`ADC_SC1_CH_LO]))
        else $error("Channel route not taken from write");

    div_four_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        s_reg.tick && converter_config_reg_i == `ADC_CFG_EXAMPLE && $stable(converter_config_reg_i)
        ##1 converter_config_reg_i == `ADC_CFG_EXAMPLE [*4] |-> !$past(s_reg.tick, 3)
        && !$past(s_reg.tick, 2) && !$past(s_reg.tick) && s_reg.tick)
        else $error("Bus clock divide by four not kept");

    cont_restart_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_done && s_reg.cont && !hw_trig && s_reg.phase == adc_conv_pkg::CTL_CONVERT
        && !conv_control_one_wr_i |=> s_reg.start)
        else $error("Continuous mode did not restart");

    irq_tie_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(conv_irq_o) |-> $past(seq_done) && $past(s_reg.aien)
        && (!$past(conv_control_two_i[`ADC_SC2_CMPEN]) || $past(cmp_met)))
        else $error("Interrupt without a qualifying completion");

    single_conv_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        wr_go ##[1:400] $rose(conversion_done_flag_o));
    compare_hit_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        conv_control_two_i[`ADC_SC2_CMPEN] && $rose(conversion_done_flag_o));
    rtc_start_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        hw_trig && s_reg.start);
    abort_c: cover property (@(posedge mclk_i) disable iff (rst_i)
        sampling_o && conv_control_one_wr_i);
endmodule
`default_nettype wire

// ==== adc_analog_model.sv ====
// Analog inputs and comparator seen by the conversion control block
`timescale 1ns/100ps
`default_nettype none
module adc_analog_model
(
    input  wire logic [4:0]  channel_route_i,
    input  wire logic [11:0] trial_code_i,
    output logic             cmp_hi_o
);
    logic [11:0] level [32];

    initial
    begin
        for (int i = 0; i < 32; i++)
            level[i] = 12'h000;
        level[5'h1a] = 12'h5a3; // Temperature level, arbitrary
        level[5'h1b] = 12'h5d1; // Bandgap level, arbitrary
        level[5'h1d] = 12'hfff; // Supply rail
        level[5'h1e] = 12'h000; // Ground rail
    end

    // Input at or above trial code
    assign cmp_hi_o = (level[channel_route_i] >= trial_code_i);
endmodule
`default_nettype wire

// ==== adc_conversion_control_test.sv ====
// Self-checking bench for the conversion control block
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_control_test;
    logic        mclk_i;
    logic        rst_i;
    logic [7:0]  cfg;
    logic        wr;
    logic [7:0]  ctl1;
    logic [7:0]  ctl2;
    logic [11:0] cmpval;
    logic [23:0] pins;
    logic        rd;
    logic        rtc;
    logic        ext_clk;
    logic        int_clk;
    logic        cmp_hi;
    logic        done;
    logic [11:0] result;
    logic        irq;
    logic [4:0]  route;
    logic [23:0] psel;
    logic        samp;
    logic [11:0] trial;
    int          n_fail;
    int          check_count;
    int          samp_cnt;
    int          ph;
    logic [4:0]  ch;
    logic [7:0]  cfgs [5] = '{8'h54, 8'hc4, 8'h45, 8'h46, 8'h47};
    logic [4:0]  inner [4] = '{5'h1a, 5'h1b, 5'h1d, 5'h1e};

    adc_conversion_control u_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .converter_config_reg_i(cfg),
        .conv_control_one_wr_i(wr), .conv_control_one_i(ctl1), .conv_control_two_i(ctl2),
        .compare_value_reg_i(cmpval), .pin_analog_control_i(pins), .result_read_i(rd),
        .rtc_trigger_i(rtc), .ext_ref_clk_i(ext_clk), .int_async_clk_i(int_clk),
        .analog_cmp_hi_i(cmp_hi), .conversion_done_flag_o(done), .conversion_result_reg_o(result),
        .conv_irq_o(irq), .channel_route_o(route), .pin0_analog_select_o(psel),
        .sampling_o(samp), .trial_code_o(trial));

    adc_analog_model u_model (.channel_route_i(route), .trial_code_i(trial), .cmp_hi_o(cmp_hi));

    initial
    begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    // External clock every cycle, internal clock every three
    always @(posedge mclk_i)
    begin
        #1;
        ext_clk = ~ext_clk;
        ph = (ph + 1) % 3;
        if (ph == 0)
            int_clk = ~int_clk;
    end

    always @(negedge mclk_i)
        if (samp === 1'b1)
            samp_cnt <= samp_cnt + 1;

    // Clock cycles per conversion tick
    function automatic int tick_div(input logic [7:0] c);
        int d;
        d = (c[1:0] == 2'h0) ? 1 : (c[1:0] == 2'h3) ? 6 : 2;
        d = d << c[6:5];
        return c[7] ? d * 2 : d;
    endfunction

    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic write1(input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        ctl1 = d;
        wr = 1'b1;
        samp_cnt = 0;
        @(posedge mclk_i);
        #1;
        wr = 1'b0;
    endtask

    task automatic convert(input logic [7:0] c1, input logic [11:0] lvl, input bit hit, input bit hw);
        int k;
        int d;
        int sp;
        u_model.level[c1[4:0]] = lvl;
        write1(c1);
        check("done cleared", 12'h000, {11'h0, done});
        check("route", {7'h0, c1[4:0]}, {7'h0, route});
        if (hw)
        begin
            repeat (100) @(posedge mclk_i);
            #1;
            check("idle until trigger", 12'h000, samp_cnt[11:0]);
            rtc = 1'b1;
            @(posedge mclk_i);
            #1;
            rtc = 1'b0;
        end
        for (k = 0; k < 1000 && done !== 1'b1; k++)
        begin
            @(posedge mclk_i);
            #1;
        end
        check("done", {11'h0, hit}, {11'h0, done});
        check("trial code", lvl, trial);
        check("irq", {11'h0, hit & c1[6]}, {11'h0, irq});
        if (hit)
        begin
            d = tick_div(cfg);
            sp = (cfg[4] ? 24 : 4) * d;
            check("result", lvl, result);
            check("sample span", 12'h001, {11'h0, samp_cnt <= sp && samp_cnt > sp - d});
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk_i);
        n_fail++;
        tally_and_finish;
    end

    initial
    begin
        void'($urandom(45));
        {rst_i, wr, rd, rtc, ext_clk, int_clk, ph, n_fail, check_count, samp_cnt} = '0;
        rst_i = 1'b1;
        {cfg, ctl1, ctl2, cmpval, pins} = '0;
        repeat (6) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        check("reset route", 12'h01f, {7'h0, route});
        check("reset flags", 12'h000, {10'h0, done, irq});
        check("reset result", 12'h000, result);
        cfg = 8'h44;
        for (int i = 0; i < 8; i++)
        begin
            ch = 5'($urandom_range(23));
            pins = 24'($urandom);
            convert({1'b0, 1'($urandom), 1'b0, ch}, 12'($urandom), 1, 0);
            check("pin select low", pins[11:0], psel[11:0]);
            check("pin select high", pins[23:12], psel[23:12]);
        end
        foreach (inner[i])
            convert({3'h2, inner[i]}, u_model.level[inner[i]], 1, 0);
        foreach (cfgs[i])
        begin
            cfg = cfgs[i];
            convert(8'h43, 12'($urandom), 1, 0);
        end
        cfg = 8'h40;
        convert(8'h43, 12'($urandom_range(255)), 1, 0);
        cfg = 8'h48;
        convert(8'h43, 12'($urandom_range(1023)), 1, 0);
        cfg = 8'h44;
        cmpval = 12'h800;
        ctl2 = 8'h30;
        convert(8'h41, 12'h800, 1, 0);
        convert(8'h41, 12'h7ff, 0, 0);
        ctl2 = 8'h20;
        convert(8'h42, 12'h7ff, 1, 0);
        convert(8'h42, 12'h800, 0, 0);
        ctl2 = 8'h00;
        u_model.level[4] = 12'h123;
        write1(8'h04);
        repeat (30) @(posedge mclk_i);
        convert(8'h05, 12'habc, 1, 0);
        @(posedge mclk_i);
        #1;
        rd = 1'b1;
        @(posedge mclk_i);
        #1;
        rd = 1'b0;
        check("read clears done", 12'h000, {11'h0, done});
        convert(8'h25, 12'h3c5, 1, 0);
        @(posedge mclk_i);
        #1;
        check("continuous restart", 12'h001, {11'h0, samp});
        write1(8'h1f);
        repeat (100) @(posedge mclk_i);
        #1;
        check("off channel idle", 12'h000, {10'h0, done, samp});
        ctl2 = 8'h40;
        convert(8'h47, 12'h9e6, 1, 1);
        tally_and_finish;
    end
endmodule
`default_nettype wire
